//--- design/lstec_pkg.sv
// Package for the line timing and exposure controller.
// Assumes a single 125 MHz system clock; all durations are counted in its cycles.
package lstec_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int LSTEC_CNT_W = 32;
    localparam int LSTEC_SRC_W = 2;
    localparam int LSTEC_NUM_SRC = 4;

    // ----------------------------------------
    // Clock
    // ----------------------------------------
    localparam int LSTEC_CLK_MHZ = 125;
    localparam int LSTEC_CLK_NS = 8;

    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    typedef enum logic [1:0] {
        LSTEC_EXP_OFF = 2'h0,
        LSTEC_EXP_TIMED = 2'h1,
        LSTEC_EXP_PULSE = 2'h2
    } lstec_scheme_t;

    // Polarity select: bit set means rising edge / high-level span
    localparam logic LSTEC_POL_UP = 1'h1;
    localparam logic LSTEC_POL_DOWN = 1'h0;

    // Pacing target code for the line-begin event
    localparam logic [1:0] LSTEC_TGT_LINE_BEGIN = 2'h0;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [LSTEC_CNT_W-1:0] LSTEC_CNT_ZERO = 32'h0;
    localparam logic [LSTEC_CNT_W-1:0] LSTEC_CNT_ONE = 32'h1;
    localparam logic [2:0] LSTEC_SYNC_RST = 3'h0;

endpackage : lstec_pkg

//--- design/lstec_sync_if.sv
// Interface carrying the conditioned pacing input between the controller and its conditioner.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface lstec_sync_if;
    logic level;
    logic rise;
    logic fall;
    modport cond (output level, output rise, output fall);
    modport ctrl (input level, input rise, input fall);
endinterface : lstec_sync_if

//--- design/lstec_sync.sv
// Input conditioner: selects one pacing input and synchronises it.
// Assumes the pins are asynchronous to the system clock.
`timescale 1ns/1ps
module lstec_sync
    import lstec_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [LSTEC_NUM_SRC-1:0] pins,
    input wire logic [LSTEC_SRC_W-1:0] origin,
    lstec_sync_if.cond sy
);
    logic [2:0] pipe_reg;
    logic level_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pipe_reg <= LSTEC_SYNC_RST;
        end else begin
            pipe_reg <= {pipe_reg[1:0], pins[origin]};
        end
    end

    // Change counts only once stages two and three agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            level_reg <= 1'b0;
        end else if (pipe_reg[2] == pipe_reg[1]) begin
            level_reg <= pipe_reg[2];
        end
    end

    assign sy.level = level_reg;
    assign sy.rise = (pipe_reg[2] == pipe_reg[1]) && pipe_reg[2] && !level_reg;
    assign sy.fall = (pipe_reg[2] == pipe_reg[1]) && !pipe_reg[2] && level_reg;
endmodule : lstec_sync

//--- design/lstec_top.sv
// Line timing and exposure controller for a line-scan sensor.
// Assumes configuration ports are held steady by software and pins are asynchronous.
`timescale 1ns/1ps
module lstec_top
    import lstec_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // Pacing pins
    input wire logic [LSTEC_NUM_SRC-1:0] PACING_PINS,
    // Configuration
    input wire logic EXTERNAL_PACING_ON,
    input wire logic [1:0] PACING_TARGET_SELECT,
    input wire logic [LSTEC_SRC_W-1:0] PACING_INPUT_ORIGIN,
    input wire logic PACING_POLARITY_SELECT,
    input wire logic [1:0] EXPOSURE_SCHEME,
    input wire logic [LSTEC_CNT_W-1:0] EXPOSURE_DURATION,
    input wire logic [LSTEC_CNT_W-1:0] FREE_RUN_LINE_PERIOD,
    // Sensor side
    output logic LINE_BEGIN,
    output logic EXPOSE,
    output logic TRIGGER_OVERRUN
);
    import lstec_pkg::*;

    lstec_sync_if sy();
    lstec_scheme_t scheme;
    logic trig_en;
    logic start_edge;
    logic stop_edge;
    logic timed_len_ok;
    logic ext_start;
    logic int_start;
    logic line_start;
    logic [LSTEC_CNT_W-1:0] exp_limit;
    logic [LSTEC_CNT_W-1:0] run_cnt_reg;
    logic [LSTEC_CNT_W-1:0] exp_cnt_reg;
    logic [LSTEC_CNT_W-1:0] last_period_reg;
    logic [LSTEC_CNT_W-1:0] period_cnt_reg;
    logic line_begin_reg;
    logic expose_reg;
    logic overrun_reg;

    // ----------------------------------------
    // Input conditioning
    // ----------------------------------------
    // origin selects pin
    lstec_sync u_sync (
        .clk(CLK_SYS),
        .nrst(NRST),
        .pins(PACING_PINS),
        .origin(PACING_INPUT_ORIGIN),
        .sy(sy)
    );

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    // illegal code, or pulse without trigger, falls back to no control
    always_comb begin
        scheme = LSTEC_EXP_OFF;
        if (EXPOSURE_SCHEME == LSTEC_EXP_TIMED) begin
            scheme = LSTEC_EXP_TIMED;
        end else if (EXPOSURE_SCHEME == LSTEC_EXP_PULSE && EXTERNAL_PACING_ON) begin
            scheme = LSTEC_EXP_PULSE;
        end
    end

    // only the line-begin target paces lines
    assign trig_en = EXTERNAL_PACING_ON && (PACING_TARGET_SELECT == LSTEC_TGT_LINE_BEGIN);

    // polarity chooses edge; pulse starts on active level onset
    assign start_edge = (PACING_POLARITY_SELECT == LSTEC_POL_UP) ? sy.rise : sy.fall;
    assign stop_edge = (PACING_POLARITY_SELECT == LSTEC_POL_UP) ? sy.fall : sy.rise;

    assign ext_start = trig_en && start_edge;
    assign int_start = !EXTERNAL_PACING_ON && (run_cnt_reg == LSTEC_CNT_ZERO);
    assign line_start = ext_start || int_start;

    // free-run exposure never exceeds one line period
    // up to one full line is accepted
    assign exp_limit = (!EXTERNAL_PACING_ON && EXPOSURE_DURATION > FREE_RUN_LINE_PERIOD)
        ? FREE_RUN_LINE_PERIOD : EXPOSURE_DURATION;
    assign timed_len_ok = exp_limit != LSTEC_CNT_ZERO;

    // ----------------------------------------
    // Internal line rate
    // ----------------------------------------
    // free-running period in clock cycles
    always_ff @(posedge CLK_SYS) begin
        if (!NRST || EXTERNAL_PACING_ON) begin
            run_cnt_reg <= LSTEC_CNT_ZERO;
        end else if (run_cnt_reg == LSTEC_CNT_ZERO) begin
            run_cnt_reg <= (FREE_RUN_LINE_PERIOD > LSTEC_CNT_ONE)
                ? FREE_RUN_LINE_PERIOD - LSTEC_CNT_ONE : LSTEC_CNT_ZERO;
        end else begin
            run_cnt_reg <= run_cnt_reg - LSTEC_CNT_ONE;
        end
    end

    // Measured trigger period; the cycle count feeds the trigger spacing check
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            period_cnt_reg <= LSTEC_CNT_ONE;
            last_period_reg <= LSTEC_CNT_ZERO;
        end else if (ext_start) begin
            period_cnt_reg <= LSTEC_CNT_ONE;
            last_period_reg <= period_cnt_reg;
        end else if (period_cnt_reg != {LSTEC_CNT_W{1'b1}}) begin
            period_cnt_reg <= period_cnt_reg + LSTEC_CNT_ONE;
        end
    end

    // ----------------------------------------
    // Line begin pulse
    // ----------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            line_begin_reg <= 1'b0;
        end else begin
            line_begin_reg <= line_start;
        end
    end

    // ----------------------------------------
    // Exposure
    // ----------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            expose_reg <= 1'b0;
            exp_cnt_reg <= LSTEC_CNT_ZERO;
        end else begin
            unique case (scheme)
                // timed exposure from line start, counted in cycles
                LSTEC_EXP_TIMED: begin
                    if (line_start && timed_len_ok) begin
                        expose_reg <= 1'b1;
                        exp_cnt_reg <= exp_limit - LSTEC_CNT_ONE;
                    end else if (exp_cnt_reg != LSTEC_CNT_ZERO) begin
                        exp_cnt_reg <= exp_cnt_reg - LSTEC_CNT_ONE;
                    end else begin
                        expose_reg <= 1'b0;
                    end
                end
                // expose exactly while the input holds its active level
                LSTEC_EXP_PULSE: begin
                    exp_cnt_reg <= LSTEC_CNT_ZERO;
                    if (ext_start) begin
                        expose_reg <= 1'b1;
                    end else if (stop_edge || !trig_en) begin
                        expose_reg <= 1'b0;
                    end
                end
                // exposure spans the whole line period
                LSTEC_EXP_OFF: begin
                    exp_cnt_reg <= LSTEC_CNT_ZERO;
                    if (line_start) begin
                        expose_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Trigger spacing check
    // ----------------------------------------
    // flag triggers closer than the programmed exposure
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            overrun_reg <= 1'b0;
        end else if (ext_start && scheme == LSTEC_EXP_TIMED) begin
            // Exposure ending on this very edge is not an overlap
            overrun_reg <= (exp_cnt_reg != LSTEC_CNT_ZERO) || (period_cnt_reg < EXPOSURE_DURATION);
        end
    end

    assign LINE_BEGIN = line_begin_reg;
    assign EXPOSE = expose_reg;
    assign TRIGGER_OVERRUN = overrun_reg;
endmodule : lstec_top

//--- verification/lstec_monitor.sv
// Checker for the line timing and exposure controller, bound to the top ports.
// Assumes the bench uses duration 3, period 5 and pulse width 6.
`timescale 1ns/1ps
module lstec_monitor
    import lstec_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic EXTERNAL_PACING_ON,
    input wire logic [1:0] PACING_TARGET_SELECT,
    input wire logic [1:0] EXPOSURE_SCHEME,
    input wire logic [LSTEC_CNT_W-1:0] EXPOSURE_DURATION,
    input wire logic [LSTEC_CNT_W-1:0] FREE_RUN_LINE_PERIOD,
    input wire logic LINE_BEGIN,
    input wire logic EXPOSE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    line_pulse_a: assert property (LINE_BEGIN |=> !LINE_BEGIN)
        else $error("line pulse too long");
    exp_start_a: assert property (EXPOSURE_SCHEME == 2'h1 && $rose(EXPOSE) |-> LINE_BEGIN)
        else $error("timed exposure began without a line");
    exp_len_a: assert property (EXPOSURE_SCHEME == 2'h1 && EXPOSURE_DURATION == 32'h3
        && LINE_BEGIN |-> (EXPOSE[*3] ##1 !EXPOSE) or (##[1:2] LINE_BEGIN))
        else $error("timed exposure length wrong");
    line_exp_a: assert property (LINE_BEGIN && EXPOSURE_SCHEME != 2'h2
        && EXPOSURE_DURATION != 32'h0 |-> EXPOSE)
        else $error("line began without exposure");
    off_hold_a: assert property (EXPOSURE_SCHEME == 2'h0 && EXPOSE |=> EXPOSE)
        else $error("exposure dropped in off scheme");
    free_period_a: assert property (!EXTERNAL_PACING_ON && FREE_RUN_LINE_PERIOD == 32'h5
        && LINE_BEGIN |=> !LINE_BEGIN[*4] ##1 LINE_BEGIN)
        else $error("free-run line period wrong");
    target_ign_a: assert property (EXTERNAL_PACING_ON && PACING_TARGET_SELECT != 2'h0
        && $past(PACING_TARGET_SELECT, 5) != 2'h0 |-> !LINE_BEGIN)
        else $error("line began with another target");
    pulse_len_a: assert property (EXTERNAL_PACING_ON && EXPOSURE_SCHEME == 2'h2
        && $rose(EXPOSE) |-> EXPOSE[*6] ##1 !EXPOSE)
        else $error("pulse exposure length wrong");
endmodule : lstec_monitor
bind lstec_top lstec_monitor i_lstec_monitor (.*);

//--- verification/lstec_trig_src.sv
// Trigger source model: one selected pin pulses, the others toggle every cycle.
// Assumes fire is a one-cycle request from the bench.
`timescale 1ns/1ps
module lstec_trig_src
    import lstec_pkg::*;
(
    input wire logic clk,
    input wire logic fire,
    input wire logic pol_up,
    input wire logic [LSTEC_SRC_W-1:0] origin,
    input wire logic [7:0] width,
    output logic [LSTEC_NUM_SRC-1:0] pins
);
    logic [7:0] left_reg = 8'h0;
    logic tog_reg = 1'h0;
    always_ff @(posedge clk) begin
        tog_reg <= ~tog_reg;
        left_reg <= fire ? width : (left_reg != 8'h0 ? left_reg - 8'h1 : 8'h0);
    end
    // active level follows polarity; idle pins noisy to expose bad selection
    always_comb begin
        pins = {LSTEC_NUM_SRC{tog_reg}};
        pins[origin] = (left_reg != 8'h0) ? pol_up : ~pol_up;
    end
endmodule : lstec_trig_src

//--- verification/tb_line_scan_trigger_exposure_ctrl.sv
// Self-checking bench for the line timing and exposure controller.
// Assumes the trigger source model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_line_scan_trigger_exposure_ctrl;
    import lstec_pkg::*;
    logic clk_sys = 1'h0;
    logic nrst = 1'h0;
    logic ext_on = 1'h0;
    logic pol_up = 1'h1;
    logic fire = 1'h0;
    logic [1:0] origin = 2'h0;
    logic [1:0] target = 2'h0;
    logic [1:0] scheme = 2'h1;
    logic [7:0] wid = 8'h1;
    logic [31:0] dur = 32'h3;
    logic [LSTEC_NUM_SRC-1:0] pins;
    logic line_begin, expose, overrun;
    int errors = 0, n_checks = 0, n_line = 0, n_exp = 0, l0 = 0, e0 = 0, cyc = 0;
    always #4 clk_sys = ~clk_sys;
    lstec_trig_src i_lstec_trig_src (.clk(clk_sys), .fire(fire), .pol_up(pol_up),
        .origin(origin), .width(wid), .pins(pins));
    lstec_top i_lstec_top (.CLK_SYS(clk_sys), .NRST(nrst), .PACING_PINS(pins),
        .EXTERNAL_PACING_ON(ext_on), .PACING_TARGET_SELECT(target),
        .PACING_INPUT_ORIGIN(origin), .PACING_POLARITY_SELECT(pol_up),
        .EXPOSURE_SCHEME(scheme), .EXPOSURE_DURATION(dur), .FREE_RUN_LINE_PERIOD(32'h5),
        .LINE_BEGIN(line_begin), .EXPOSE(expose), .TRIGGER_OVERRUN(overrun));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // Line and exposure cycles are counted here; the run is cut short if it hangs
    always @(posedge clk_sys) begin
        n_line += line_begin;
        n_exp += expose;
        cyc++;
        if (cyc == 2000) begin
            errors++;
            end_sim();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic setup(input logic e, input logic [1:0] s, input logic p,
        input logic [1:0] o, input logic [1:0] t, input logic [7:0] w);
        @(posedge clk_sys);
        nrst <= 1'h0;
        ext_on <= e;
        scheme <= s;
        pol_up <= p;
        origin <= o;
        target <= t;
        wid <= w;
        dur <= 32'h3;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'h1;
        repeat (4) @(posedge clk_sys);
        #1;
        l0 = n_line;
        e0 = n_exp;
    endtask : setup
    task automatic pulse(input int gap);
        @(posedge clk_sys);
        fire <= 1'h1;
        @(posedge clk_sys);
        fire <= 1'h0;
        repeat (gap) @(posedge clk_sys);
    endtask : pulse
    // Expose count below zero means it is not judged
    task automatic look(input string what, input int nl, input int ne);
        #1;
        chk({what, " lines"}, n_line - l0, nl);
        if (ne >= 0) begin
            chk({what, " expose"}, n_exp - e0, ne);
        end
        $display("test %s done", what);
    endtask : look
    task automatic t_timed(input logic [1:0] o);
        // Pulses must last two samples to pass the synchroniser
        setup(1'h1, 2'h1, o[0], o, 2'h0, 8'h2);
        pulse(12);
        pulse(12);
        look("timed", 2, 6);
        chk("overrun clear", overrun, 32'h0);
        // Triggers four cycles apart under a five-cycle exposure break the spacing
        @(posedge clk_sys);
        dur <= 32'h5;
        pulse(2);
        pulse(12);
        look("retrigger", 4, 15);
        chk("overrun set", overrun, 32'h1);
    endtask : t_timed
    task automatic t_misc();
        setup(1'h1, 2'h2, 1'h1, 2'h2, 2'h0, 8'h6);
        pulse(14);
        look("pulse high", 1, 6);
        setup(1'h1, 2'h2, 1'h0, 2'h1, 2'h0, 8'h6);
        pulse(14);
        look("pulse low", 1, 6);
        setup(1'h1, 2'h0, 1'h1, 2'h3, 2'h0, 8'h2);
        pulse(12);
        chk("off held", expose, 32'h1);
        pulse(12);
        look("trig off", 2, -1);
        setup(1'h0, 2'h1, 1'h1, 2'h0, 2'h0, 8'h2);
        repeat (20) @(posedge clk_sys);
        look("free timed", 4, 12);
        setup(1'h0, 2'h0, 1'h1, 2'h0, 2'h0, 8'h2);
        repeat (10) @(posedge clk_sys);
        look("free off", 2, 10);
        setup(1'h1, 2'h1, 1'h1, 2'h1, 2'h1, 8'h2);
        pulse(12);
        look("target", 0, 0);
    endtask : t_misc
    initial begin
        for (int i = 0; i < 4; i++) begin
            t_timed(i[1:0]);
        end
        t_misc();
        end_sim();
    end
endmodule : tb_line_scan_trigger_exposure_ctrl
